// File: test/iec_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
// Core stand-in: takes an offered interrupt after a chosen wait
module iec_cpu_model (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [1:0] ack_dly,
   input  wire logic       irq_req,
   input  wire logic [9:0] irq_vector,
   output logic            irq_ack,
   output logic [9:0]      taken_vec,
   output int              n_taken
);
   logic [1:0] wait_reg;
   // Ack is one pulse; the wait models a core finishing its instruction
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_ack   <= 1'b0;
         wait_reg  <= 2'h0;
         taken_vec <= 10'h000;
         n_taken   <= 0;
      end
      else if (irq_ack || !irq_req)
      begin
         irq_ack  <= 1'b0;
         wait_reg <= 2'h0;
      end
      else if (wait_reg >= ack_dly)
      begin
         irq_ack   <= 1'b1;
         taken_vec <= irq_vector;
         n_taken   <= n_taken + 1;
      end
      else
         wait_reg <= wait_reg + 2'h1;
   end
endmodule
`default_nettype wire

// File: test/iec_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module interrupt_and_event_transfer_ctrl_tb_top;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata, rd, hw_req = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq_req, irq_ack, tvv, xv, xword, evt_irq;
   logic [1:0]  bresp, rresp, rsp, ext_pin = 2'h0, ack_dly = 2'h1;
   logic [3:0]  cpu_level = 4'h0, irq_level, share = 4'h0;
   logic        trap_valid = 1'b0;
   logic [7:0]  trap_num = 8'h00;
   logic [9:0]  irq_vector, trap_vector, taken_vec;
   logic [23:0] xsrc, xdst;
   int          n_taken, n_xfer = 0, bad_count = 0, n_checks = 0, mark;
   // Free-running 50 MHz clock
   always #10 aclk = ~aclk;
   iec_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .hw_req(hw_req), .share_req(share), .ext_pin(ext_pin), .cpu_level(cpu_level),
      .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level), .irq_ack(irq_ack),
      .trap_valid(trap_valid), .trap_num(trap_num), .trap_vec_valid(tvv),
      .trap_vector(trap_vector), .xfer_valid(xv), .xfer_src(xsrc), .xfer_dst(xdst),
      .xfer_word(xword), .evt_irq(evt_irq));
   iec_cpu_model cpu (.aclk(aclk), .aresetn(aresetn), .ack_dly(ack_dly), .irq_req(irq_req),
      .irq_vector(irq_vector), .irq_ack(irq_ack), .taken_vec(taken_vec), .n_taken(n_taken));
   // Count stolen cycles away from the launching edge
   always @(negedge aclk) if (xv === 1'b1) n_xfer++;
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      do @(negedge aclk); while (!(awready && wready));
      @(posedge aclk);
      {awvalid, wvalid} <= 2'h0;
      do @(negedge aclk); while (!bvalid);
      rsp = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask
   task automatic rdr(input logic [11:0] a);
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do @(negedge aclk); while (!arready);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (!rvalid);
      rd = rdata;
      rsp = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask
   task automatic hit(input int n);
      @(posedge aclk);
      hw_req[n] <= 1'b1;
      @(posedge aclk);
      hw_req[n] <= 1'b0;
   endtask
   // Bounded wait for the core stand-in to take a new vector
   task automatic wt(input logic [9:0] v);
      repeat (20) if (n_taken == mark) @(negedge aclk);
      `CHK({n_taken != mark, taken_vec}, {1'b1, v})
      @(posedge aclk);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Hang guard, well beyond the few hundred cycles the tests need
   initial
   begin
      repeat (8000) @(posedge aclk);
      bad_count++;
      $display("[ERR] %0t watchdog expired", $time);
      wrap_up();
   end
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rdr(12'h060);
      `CHK(rd, 32'h0)
      rdr(12'h300);
      `CHK(rsp, 2'h2)
      wr(12'h300, 32'h1);
      `CHK(rsp, 2'h2)
      wr(12'h060, 32'h105);
      `CHK(rsp, 2'h0)
      mark = n_taken;
      hit(24);
      wt(10'h0A0);
      rdr(12'h060);
      `CHK(rd, 32'h105)
      $display("vector test done");
      // Equal level must wait, one level lower lets it through
      cpu_level <= 4'h5;
      hit(24);
      repeat (6) @(negedge aclk);
      `CHK(irq_req, 1'b0)
      rdr(12'h060);
      `CHK(rd, 32'h305)
      mark = n_taken;
      cpu_level <= 4'h4;
      wt(10'h0A0);
      // Two software requests held back, then the higher level goes first
      cpu_level <= 4'hF;
      ack_dly <= 2'h3;
      wr(12'h028, 32'h303);
      wr(12'h02C, 32'h309);
      mark = n_taken;
      cpu_level <= 4'h0;
      wt(10'h06C);
      mark = n_taken;
      wt(10'h068);
      `CHK(irq_level, 4'h3)
      $display("priority test done");
      @(posedge aclk);
      trap_num <= 8'h28;
      trap_valid <= 1'b1;
      @(posedge aclk);
      trap_valid <= 1'b0;
      @(negedge aclk);
      `CHK({tvv, trap_vector}, 11'h4A0)
      wr(12'h204, 32'h100);
      `CHK(evt_irq, 1'b1)
      wr(12'h200, 32'h100);
      `CHK(evt_irq, 1'b0)
      $display("trap test done");
      // Channel 1: word moves, both pointers step, two transfers then interrupt
      wr(12'h014, 32'h192);
      wr(12'h110, 32'h100);
      wr(12'h114, 32'h200);
      wr(12'h118, 32'h2);
      wr(12'h11C, 32'h7);
      hit(5);
      repeat (4) @(negedge aclk);
      `CHK({n_xfer[1:0], xword, xsrc}, {2'h1, 1'b1, 24'h000100})
      rdr(12'h110);
      `CHK(rd, 32'h102)
      rdr(12'h118);
      `CHK(rd, 32'h1)
      hit(5);
      rdr(12'h200);
      `CHK({rd[1], xdst}, {1'b1, 24'h000202})
      mark = n_taken;
      hit(5);
      wt(10'h054);
      `CHK(n_xfer, 2)
      // Continuous mode keeps a zero count and moves anyway
      wr(12'h11C, 32'h9);
      hit(5);
      rdr(12'h118);
      `CHK({n_xfer[1:0], rd}, {2'h3, 32'h0})
      rdr(12'h110);
      `CHK(rd, 32'h104)
      $display("transfer test done");
      // Shared serial source reaches the node of trap 14h
      wr(12'h010, 32'h101);
      mark = n_taken;
      share[0] <= 1'b1;
      @(posedge aclk);
      share[0] <= 1'b0;
      wt(10'h050);
      $display("shared source test done");
      // Rise, fall, then a rise in both-edges mode on the first fast input
      wr(12'h038, 32'h103);
      for (int i = 1; i < 4; i++)
      begin
         wr(12'h208, 32'(i));
         mark = n_taken;
         ext_pin[0] <= ~ext_pin[0];
         wt(10'h078);
      end
      $display("edge test done");
      wrap_up();
   end
endmodule
`default_nettype wire

// File: verilog/iec_ctrl.sv
// How it works
// RULE1 - Offer accepted request fast, core budget 7/11
// RULE2 - Each node routes to vectored interrupt or transfer
// RULE3 - Interrupt branches to vector; transfer steals one cycle
// RULE4 - Move one byte/word, then bump chosen pointers
// RULE5 - Count down per transfer, held in continuous mode
// RULE6 - Count at zero raises node interrupt instead; in continuous mode the code transfers anyway
// RULE7 - Eight independent transfer channels
// RULE8 - Per-node control: request, enable, priority
// RULE9 - Sixteen priority levels arbitrate pending requests
// RULE10 - Only strictly higher priority preempts running service
// RULE11 - Every node owns its own vector
// RULE12 - Fast external inputs: rising, falling or both edges
// RULE13 - Trap number invokes its matching vector
// RULE14 - Software may set request bits like hardware
// RULE15 - Vector offset is four times trap number
// RULE16 - Node of trap 14h also takes shared serial source
// RULE17 - Request flag clears on acceptance, else stays
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "iec_defs.svh"
module iec_ctrl #(
   parameter int NODES = 32,
   parameter int EXTS  = 2,
   parameter int AW    = 24
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [11:0]       s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [11:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [NODES-1:0]  hw_req,
   input  wire logic [3:0]        share_req,
   input  wire logic [EXTS-1:0]   ext_pin,
   input  wire logic [3:0]        cpu_level,
   output logic                   irq_req,
   output logic [9:0]             irq_vector,
   output logic [3:0]             irq_level,
   input  wire logic              irq_ack,
   input  wire logic              trap_valid,
   input  wire logic [7:0]        trap_num,
   output logic                   trap_vec_valid,
   output logic [9:0]             trap_vector,
   output logic                   xfer_valid,
   output logic [AW-1:0]          xfer_src,
   output logic [AW-1:0]          xfer_dst,
   output logic                   xfer_word,
   output logic                   evt_irq
);
   localparam int CHANS = `IEC_CHANS; // see RULE7
   localparam int SW    = CHANS + 1;

   iec_pkg::iec_node_s  node_reg  [NODES];
   iec_pkg::iec_node_s  node_next [NODES];
   iec_pkg::iec_chcfg_s cfg_reg   [CHANS];
   logic [AW-1:0]       src_reg   [CHANS];
   logic [AW-1:0]       dst_reg   [CHANS];
   logic [15:0]         cnt_reg   [CHANS];
   iec_pkg::iec_state_e st_reg;
   logic [SW-1:0]       status_reg;
   logic [SW-1:0]       mask_reg;
   logic [2*EXTS-1:0]   edge_reg;
   logic [4:0]          lat_reg;
   logic [2:0]          xch_reg;
   logic                irq_req_reg;
   logic [9:0]          irq_vec_reg;
   logic [3:0]          irq_lvl_reg;
   logic                xfer_reg;
   logic [AW-1:0]       xsrc_reg;
   logic [AW-1:0]       xdst_reg;
   logic                xword_reg;
   logic                tvalid_reg;
   logic [9:0]          tvec_reg;
   logic                bvalid_reg;
   logic [1:0]          bresp_reg;
   logic                rvalid_reg;
   logic [31:0]         rdata_reg;
   logic [1:0]          rresp_reg;
   logic [EXTS-1:0]     ext_evt;
   logic [NODES-1:0]    src_set;
   logic                win_found;
   logic [4:0]          win_idx;
   logic [3:0]          win_prio;
   logic                win_ok;
   logic                win_xfer;
   logic [2:0]          win_ch;
   logic                xfer_go;
   logic                int_go;
   logic                wr_go;
   logic                rd_go;
   logic [31:0]         rd_data;
   logic                rd_ok;
   logic                wr_ok;
   logic [SW-1:0]       ev_set;

   // Byte-lane merge for writes
   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
            r[8*b +: 8] = new_v[8*b +: 8];
      end
      return r;
   endfunction

   // Vector offset from a trap number
   function automatic logic [9:0] vec_of(input logic [7:0] trap);
      return {trap, 2'b00}; // see RULE15
   endfunction

   // Node index to trap number
   function automatic logic [7:0] trap_of(input logic [4:0] idx);
      return `IEC_TRAP_BASE + {3'h0, idx};
   endfunction

   iec_edge_sel #(.N(EXTS)) u_edge (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (ext_pin),
      .mode    (edge_reg),
      .evt     (ext_evt)
   );

   // Hardware sources per node; shared and fast external sources are ORed in
   always_comb
   begin
      src_set = hw_req;
      for (int k = 0; k < 4; k++)
         src_set[`IEC_SHARE_NODE + k] = hw_req[`IEC_SHARE_NODE + k] | share_req[k]; // see RULE16
      for (int k = 0; k < EXTS; k++)
         src_set[`IEC_EXT_NODE + k] = src_set[`IEC_EXT_NODE + k] | ext_evt[k]; // see RULE12
   end

   // Highest level wins, lowest index breaks ties
   always_comb
   begin
      win_found = 1'b0;
      win_idx   = 5'h00;
      win_prio  = 4'h0;
      for (int i = 0; i < NODES; i++)
      begin
         if (node_reg[i].req && node_reg[i].en &&
             (!win_found || node_reg[i].prio > win_prio)) // see RULE9
         begin
            win_found = 1'b1;
            win_idx   = 5'(i);
            win_prio  = node_reg[i].prio;
         end
      end
   end

   // Routing and gating of the winner
   assign win_ch   = node_reg[win_idx].chan;
   assign win_ok   = win_found && (win_prio > cpu_level); // see RULE10
   assign win_xfer = node_reg[win_idx].use_xfer
                     && (cfg_reg[win_ch].cont || cnt_reg[win_ch] != 16'h0000); // see RULE2
   assign xfer_go  = (st_reg == iec_pkg::ST_IDLE) && win_ok && win_xfer;
   assign int_go   = (st_reg == iec_pkg::ST_IDLE) && win_ok && !win_xfer; // see RULE6

   // Bus handshakes; address and data are taken together
   assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign rd_go         = s_axi_arvalid && !rvalid_reg;
   assign s_axi_arready = !rvalid_reg;
   assign wr_ok = (s_axi_awaddr[11:7] == 5'h00 && 32'(s_axi_awaddr[6:2]) < NODES)
                  || s_axi_awaddr[11:7] == 5'h02
                  || (s_axi_awaddr[11:4] == 8'h20 && s_axi_awaddr[3:2] != 2'h3);

   // Next value of each node word; a hardware set beats any clear
   always_comb
   begin
      for (int i = 0; i < NODES; i++)
      begin
         node_next[i] = node_reg[i];
         if (wr_go && s_axi_awaddr[11:7] == 5'h00 && 32'(s_axi_awaddr[6:2]) == i)
            node_next[i] = iec_pkg::iec_node_s'(10'(merge(32'(node_reg[i]), s_axi_wdata,
                                                          s_axi_wstrb))); // see RULE14
         if ((st_reg == iec_pkg::ST_OFFER && irq_ack && 32'(lat_reg) == i) ||
             (xfer_go && 32'(win_idx) == i))
            node_next[i].req = 1'b0; // see RULE17
         if (src_set[i])
            node_next[i].req = 1'b1; // see RULE8
      end
   end

   always_ff @(posedge aclk)
   begin
      for (int i = 0; i < NODES; i++)
      begin
         if (!aresetn)
            node_reg[i] <= iec_pkg::iec_node_s'(`IEC_NODE_RST);
         else
            node_reg[i] <= node_next[i];
      end
   end

   // Channel pointers and counters; a bus write in the same cycle wins
   always_ff @(posedge aclk)
   begin
      for (int c = 0; c < CHANS; c++)
      begin
         if (!aresetn)
         begin
            src_reg[c] <= '0;
            dst_reg[c] <= '0;
            cnt_reg[c] <= 16'h0000;
            cfg_reg[c] <= '0;
         end
         else if (wr_go && s_axi_awaddr[11:7] == 5'h02 && 32'(s_axi_awaddr[6:4]) == c)
         begin
            case (s_axi_awaddr[3:2])
               `IEC_CH_SRC: src_reg[c] <= AW'(merge(32'(src_reg[c]), s_axi_wdata, s_axi_wstrb));
               `IEC_CH_DST: dst_reg[c] <= AW'(merge(32'(dst_reg[c]), s_axi_wdata, s_axi_wstrb));
               `IEC_CH_CNT: cnt_reg[c] <= 16'(merge(32'(cnt_reg[c]), s_axi_wdata, s_axi_wstrb));
               default:     cfg_reg[c] <= iec_pkg::iec_chcfg_s'(s_axi_wdata[3:0]);
            endcase
         end
         else if (xfer_go && 32'(win_ch) == c)
         begin
            if (cfg_reg[c].inc_src)
               src_reg[c] <= src_reg[c] + (cfg_reg[c].word ? AW'(2) : AW'(1)); // see RULE4
            if (cfg_reg[c].inc_dst)
               dst_reg[c] <= dst_reg[c] + (cfg_reg[c].word ? AW'(2) : AW'(1)); // see RULE4
            if (!cfg_reg[c].cont)
               cnt_reg[c] <= cnt_reg[c] - 16'h0001; // see RULE5
         end
      end
   end

   // Service sequencer: offer a vector, or steal one cycle for a move
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_reg      <= iec_pkg::ST_IDLE;
         irq_req_reg <= 1'b0;
         irq_vec_reg <= 10'h000;
         irq_lvl_reg <= 4'h0;
         lat_reg     <= 5'h00;
         xfer_reg    <= 1'b0;
         xsrc_reg    <= '0;
         xdst_reg    <= '0;
         xword_reg   <= 1'b0;
         xch_reg     <= 3'h0;
      end
      else
      begin
         xfer_reg <= 1'b0;
         case (st_reg)
            iec_pkg::ST_IDLE:
            begin
               if (xfer_go)
               begin
                  xfer_reg  <= 1'b1; // see RULE3
                  xsrc_reg  <= src_reg[win_ch];
                  xdst_reg  <= dst_reg[win_ch];
                  xword_reg <= cfg_reg[win_ch].word;
                  xch_reg   <= win_ch;
                  st_reg    <= iec_pkg::ST_STEAL;
               end
               else if (int_go)
               begin
                  irq_req_reg <= 1'b1; // see RULE1
                  irq_vec_reg <= vec_of(trap_of(win_idx)); // see RULE11
                  irq_lvl_reg <= win_prio;
                  lat_reg     <= win_idx;
                  st_reg      <= iec_pkg::ST_OFFER;
               end
            end
            iec_pkg::ST_OFFER:
            begin
               // Withdraw when a better node appears or the offer is no longer valid
               if (irq_ack || !int_ok_held())
               begin
                  irq_req_reg <= 1'b0;
                  st_reg      <= iec_pkg::ST_IDLE;
               end
            end
            iec_pkg::ST_STEAL:
               st_reg <= iec_pkg::ST_IDLE;
            default:
               st_reg <= iec_pkg::ST_IDLE;
         endcase
      end
   end

   // Offer still stands: same winner, still above the core's level
   function automatic logic int_ok_held();
      return win_ok && !win_xfer && win_idx == lat_reg;
   endfunction

   // Trap instruction to vector, one cycle later
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tvalid_reg <= 1'b0;
         tvec_reg   <= 10'h000;
      end
      else
      begin
         tvalid_reg <= trap_valid;
         if (trap_valid)
            tvec_reg <= vec_of(trap_num); // see RULE13
      end
   end

   // Channel terminal counts and traps set sticky status bits
   always_comb
   begin
      ev_set = '0;
      for (int c = 0; c < CHANS; c++)
         ev_set[c] = xfer_go && 32'(win_ch) == c && !cfg_reg[c].cont
                     && cnt_reg[c] == 16'h0001;
      ev_set[CHANS] = trap_valid;
   end

   // Write one clears; a new event in the same cycle stays set
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         status_reg <= '0;
         mask_reg   <= '0;
         edge_reg   <= '0;
      end
      else
      begin
         if (wr_go && s_axi_awaddr == `IEC_OFS_STATUS)
            status_reg <= (status_reg & ~s_axi_wdata[SW-1:0]) | ev_set;
         else
            status_reg <= status_reg | ev_set;
         if (wr_go && s_axi_awaddr == `IEC_OFS_MASK)
            mask_reg <= s_axi_wdata[SW-1:0];
         if (wr_go && s_axi_awaddr == `IEC_OFS_EDGE)
            edge_reg <= s_axi_wdata[2*EXTS-1:0];
      end
   end

   // Read decode
   always_comb
   begin
      rd_data = 32'h0000_0000;
      rd_ok   = 1'b1;
      if (s_axi_araddr[11:7] == 5'h00 && 32'(s_axi_araddr[6:2]) < NODES)
         rd_data = 32'(node_reg[s_axi_araddr[6:2]]);
      else if (s_axi_araddr[11:7] == 5'h02)
      begin
         case (s_axi_araddr[3:2])
            `IEC_CH_SRC: rd_data = 32'(src_reg[s_axi_araddr[6:4]]);
            `IEC_CH_DST: rd_data = 32'(dst_reg[s_axi_araddr[6:4]]);
            `IEC_CH_CNT: rd_data = 32'(cnt_reg[s_axi_araddr[6:4]]);
            default:     rd_data = 32'(cfg_reg[s_axi_araddr[6:4]]);
         endcase
      end
      else if (s_axi_araddr == `IEC_OFS_STATUS)
         rd_data = 32'(status_reg);
      else if (s_axi_araddr == `IEC_OFS_MASK)
         rd_data = 32'(mask_reg);
      else if (s_axi_araddr == `IEC_OFS_EDGE)
         rd_data = 32'(edge_reg);
      else if (s_axi_araddr == `IEC_OFS_STATE)
         rd_data = {21'h0, st_reg, lat_reg, irq_lvl_reg};
      else
         rd_ok = 1'b0;
   end

   // Response channels; an unmapped address answers SLVERR
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= `IEC_OKAY;
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= `IEC_OKAY;
      end
      else
      begin
         if (wr_go)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_ok ? `IEC_OKAY : `IEC_SLVERR;
         end
         else if (s_axi_bready)
            bvalid_reg <= 1'b0;
         if (rd_go)
         begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_data;
            rresp_reg  <= rd_ok ? `IEC_OKAY : `IEC_SLVERR;
         end
         else if (s_axi_rready)
            rvalid_reg <= 1'b0;
      end
   end

   assign s_axi_bvalid   = bvalid_reg;
   assign s_axi_bresp    = bresp_reg;
   assign s_axi_rvalid   = rvalid_reg;
   assign s_axi_rdata    = rdata_reg;
   assign s_axi_rresp    = rresp_reg;
   assign irq_req        = irq_req_reg;
   assign irq_vector     = irq_vec_reg;
   assign irq_level      = irq_lvl_reg;
   assign xfer_valid     = xfer_reg;
   assign xfer_src       = xsrc_reg;
   assign xfer_dst       = xdst_reg;
   assign xfer_word      = xword_reg;
   assign trap_vec_valid = tvalid_reg;
   assign trap_vector    = tvec_reg;
   assign evt_irq        = |(status_reg & mask_reg);

   sequence s_int_ready;
      st_reg == iec_pkg::ST_IDLE && win_ok && !win_xfer;
   endsequence
   sequence s_xfer_start;
      st_reg == iec_pkg::ST_IDLE && win_ok && win_xfer;
   endsequence

   property p_resp;
      @(posedge aclk) disable iff (!aresetn)
      s_int_ready |=> irq_req && irq_vector == vec_of(trap_of($past(win_idx)));
   endproperty
   a_resp: assert property (p_resp) else $error("offer late or wrong vector"); // see RULE1

   property p_steal;
      @(posedge aclk) disable iff (!aresetn)
      s_xfer_start |=> xfer_valid ##1 !xfer_valid;
   endproperty
   a_steal: assert property (p_steal) else $error("transfer not one cycle"); // see RULE3

   property p_count;
      @(posedge aclk) disable iff (!aresetn)
      xfer_valid |-> cnt_reg[xch_reg] ==
         (cfg_reg[xch_reg].cont ? $past(cnt_reg[win_ch]) : $past(cnt_reg[win_ch]) - 16'h0001);
   endproperty
   a_count: assert property (p_count) else $error("count step wrong"); // see RULE5

   property p_ptr;
      @(posedge aclk) disable iff (!aresetn)
      (xfer_valid && cfg_reg[xch_reg].inc_src) |-> src_reg[xch_reg] ==
         xfer_src + (cfg_reg[xch_reg].word ? AW'(2) : AW'(1));
   endproperty
   a_ptr: assert property (p_ptr) else $error("source pointer step wrong"); // see RULE4

   property p_zero;
      @(posedge aclk) disable iff (!aresetn)
      (st_reg == iec_pkg::ST_IDLE && win_ok && node_reg[win_idx].use_xfer
       && !cfg_reg[win_ch].cont && cnt_reg[win_ch] == 16'h0000) |=> irq_req && !xfer_valid;
   endproperty
   a_zero: assert property (p_zero) else $error("zero count did not interrupt"); // see RULE6

   property p_level;
      @(posedge aclk) disable iff (!aresetn)
      $rose(irq_req) |-> irq_level > $past(cpu_level);
   endproperty
   a_level: assert property (p_level) else $error("offer not above core level"); // see RULE10

   property p_trap;
      @(posedge aclk) disable iff (!aresetn)
      trap_valid |=> trap_vec_valid && trap_vector == vec_of($past(trap_num));
   endproperty
   a_trap: assert property (p_trap) else $error("trap vector wrong"); // see RULE13

   property p_clear;
      @(posedge aclk) disable iff (!aresetn)
      (irq_req && irq_ack && !src_set[lat_reg]) |=> !node_reg[$past(lat_reg)].req;
   endproperty
   a_clear: assert property (p_clear) else $error("flag kept after accept"); // see RULE17
endmodule
`default_nettype wire

// File: verilog/iec_defs.svh
`ifndef IEC_DEFS_SVH
`define IEC_DEFS_SVH
// Register byte offsets
`define IEC_OFS_NODE    12'h000
`define IEC_OFS_CHAN    12'h100
`define IEC_OFS_STATUS  12'h200
`define IEC_OFS_MASK    12'h204
`define IEC_OFS_EDGE    12'h208
`define IEC_OFS_STATE   12'h20C
// Word index inside one channel block
`define IEC_CH_SRC      2'h0
`define IEC_CH_DST      2'h1
`define IEC_CH_CNT      2'h2
`define IEC_CH_CFG      2'h3
// Node numbering, channel count and fixed source placement
`define IEC_TRAP_BASE   8'h10
`define IEC_CHANS       8
`define IEC_SHARE_NODE  4
`define IEC_EXT_NODE    14
// Core response budget in CPU clocks, with and without jump cache
`define IEC_RESP_MIN    7
`define IEC_RESP_NOJC   11
// Reset values and bus answers
`define IEC_NODE_RST    10'h000
`define IEC_OKAY        2'h0
`define IEC_SLVERR      2'h2
`endif

// File: verilog/iec_edge_sel.sv
`timescale 1ns/10ps
`default_nettype none
module iec_edge_sel #(
   parameter int N = 2
) (
   input  wire logic           aclk,
   input  wire logic           aresetn,
   input  wire logic [N-1:0]   pin,
   input  wire logic [2*N-1:0] mode,
   output logic      [N-1:0]   evt
);
   logic [N-1:0] sync1_reg;
   logic [N-1:0] sync2_reg;
   logic [N-1:0] prev_reg;
   logic [N-1:0] evt_reg;
   logic [N-1:0] evt_next;

   // Two stages before any logic, then a history stage for the edge
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         prev_reg  <= '0;
      end
      else
      begin
         sync1_reg <= pin;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   // Mode bit 0 picks rising, bit 1 falling, both set picks either
   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         evt_next[i] = (mode[2*i] & sync2_reg[i] & ~prev_reg[i])
                     | (mode[2*i+1] & ~sync2_reg[i] & prev_reg[i]); // see RULE12
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         evt_reg <= '0;
      else
         evt_reg <= evt_next;
   end

   assign evt = evt_reg;

   property p_edge_fall;
      @(posedge aclk) disable iff (!aresetn)
      (mode[1] && !sync2_reg[0] && prev_reg[0]) |=> evt[0];
   endproperty
   a_edge_fall: assert property (p_edge_fall) else $error("falling edge missed"); // see RULE12

   property p_edge_quiet;
      @(posedge aclk) disable iff (!aresetn)
      (mode[1:0] == 2'h0) |=> !evt[0];
   endproperty
   a_edge_quiet: assert property (p_edge_quiet) else $error("event with edges off"); // see RULE12
endmodule
`default_nettype wire

// File: verilog/iec_pkg.sv
package iec_pkg;
   // One node control word: flag, enable, routing and level
   typedef struct packed {
      logic       req;
      logic       en;
      logic       use_xfer;
      logic [2:0] chan;
      logic [3:0] prio;
   } iec_node_s;
   // Per-channel transfer options
   typedef struct packed {
      logic cont;
      logic inc_dst;
      logic inc_src;
      logic word;
   } iec_chcfg_s;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_OFFER = 2'b01,
      ST_STEAL = 2'b10
   } iec_state_e;
endpackage
